// ---- inc/scan_map.svh ----
// Register map, field positions, reset values and timing of the scan command port
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH
// Register byte offsets
`define OFF_TEST_COMMAND 8'h00
`define OFF_CYCLE_COUNT_PORT 8'h04
`define OFF_OUTBOUND_SCAN_FIFO 8'h08
`define OFF_INBOUND_SCAN_FIFO 8'h0c
`define OFF_STATUS 8'h10
`define OFF_MODE_CONFIG 8'h14
// Command register fields
`define CMD_SOFT_RESET_BIT 7
`define CMD_TRST_BIT 6
`define CMD_FINISH_HI 5
`define CMD_FINISH_LO 4
`define CMD_OP_HI 3
`define CMD_OP_LO 0
// Mode configuration field
`define CFG_DISCRETE_BIT 0
// Reset values
`define RST_TEST_COMMAND 8'h00
`define RST_MODE_CONFIG 8'h00
// Timing
`define CLK_PERIOD_NS 100
`define TCK_PERIOD_NS 800
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- inc/scan_pkg.sv ----
// Types shared by the scan command port
package scan_pkg;
	// Target TAP state as tracked by the engine
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000, TAP_SEL_DR = 4'b0001, TAP_CAP_DR = 4'b0010,
		TAP_SHIFT_DR = 4'b0011, TAP_EXIT1_DR = 4'b0100, TAP_PAUSE_DR = 4'b0101,
		TAP_EXIT2_DR = 4'b0110, TAP_UPD_DR = 4'b0111, TAP_IDLE = 4'b1000,
		TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SHIFT_IR = 4'b1011,
		TAP_EXIT1_IR = 4'b1100, TAP_PAUSE_IR = 4'b1101, TAP_EXIT2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} tap_state_t;
	// Operation codes
	typedef enum logic [3:0] {
		OP_NULL = 4'b0000, OP_RESERVED = 4'b0001, OP_RUN_TEST = 4'b0010,
		OP_ASP_IN = 4'b0011, OP_ASP_FULL = 4'b0100, OP_ASP_OUT = 4'b0101,
		OP_MOVE = 4'b0110, OP_JUMP = 4'b0111, OP_IR_FULL = 4'b1000,
		OP_DR_FULL = 4'b1001, OP_IR_IN = 4'b1010, OP_DR_IN = 4'b1011,
		OP_IR_OUT = 4'b1100, OP_DR_OUT = 4'b1101, OP_IR_RECIRC = 4'b1110,
		OP_DR_RECIRC = 4'b1111
	} op_code_t;
	// Command engine states
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b000, ENG_WAIT = 3'b001, ENG_ENTER = 3'b010,
		ENG_WORK = 3'b011, ENG_LEAVE = 3'b100
	} eng_t;
	// What an operation code needs
	typedef struct packed {
		logic valid;
		logic cnt;
		logic inb;
		logic outb;
		logic addressable_port;
		logic recirc;
		logic move_only;
		logic jump;
		tap_state_t goal;
	} op_use_t;
	// Test access port outputs
	typedef struct packed {
		logic test_clk;
		logic mode_sel;
		logic scan_out;
		logic test_reset_n;
	} tap_pins_t;
endpackage

// ---- logic/byte_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push_valid,
	output logic push_ready,
	input wire logic [WIDTH-1:0] push_data,
	output logic pop_valid,
	input wire logic pop_ready,
	output logic [WIDTH-1:0] pop_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// Whole FIFO state
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] fill;
	} fifo_st_t;
	fifo_st_t f_q, f_d;
	logic do_push, do_pop;

	assign push_ready = f_q.fill != (AW+1)'(DEPTH);
	assign pop_valid = f_q.fill != '0;
	assign pop_data = f_q.mem[f_q.rd];
	assign do_push = push_valid && push_ready;
	assign do_pop = pop_ready && pop_valid;

	// Pointer and fill update; flush empties without touching data
	always_comb begin
		f_d = f_q;
		if (do_push) begin
			f_d.mem[f_q.wr] = push_data;
			f_d.wr = (f_q.wr == AW'(DEPTH-1)) ? '0 : f_q.wr + 1'b1;
		end
		if (do_pop) begin
			f_d.rd = (f_q.rd == AW'(DEPTH-1)) ? '0 : f_q.rd + 1'b1;
		end
		f_d.fill = f_q.fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (flush) begin
			f_d.rd = '0;
			f_d.wr = '0;
			f_d.fill = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end
endmodule

// ---- logic/scan_master_command_port.sv ----
// Scan master command port: register slave, command engine and scan buffers
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "scan_map.svh"
module scan_master_command_port
	import scan_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic scan_in,
	output tap_pins_t tap_out
);
	// Test clock period in system clocks, split in two halves
	localparam int TCK_CYC = `TCK_PERIOD_NS / `CLK_PERIOD_NS;
	localparam int HALF = TCK_CYC / 2;
	localparam int PH_W = $clog2(TCK_CYC);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_free;         // Write address slot empty
		logic [7:0] aw_addr;   // Held write address
		logic w_free;          // Write data slot empty
		logic [7:0] w_data;    // Held write byte
		logic w_lane0;         // Low byte lane enabled
		logic bvalid;          // Write answer pending
		logic [1:0] bresp;     // Write answer code
		logic ar_free;         // Read address slot empty
		logic [7:0] ar_addr;   // Held read address
		logic rvalid;          // Read answer pending
		logic [7:0] rdata;     // Read answer byte
		logic [1:0] rresp;     // Read answer code
		logic [7:0] cmd;       // Test command register
		logic [7:0] cfg;       // Mode configuration register
		logic [31:0] count;    // Test cycle counter
		logic [1:0] wr_idx;    // Next counter byte to write
		logic [1:0] rd_idx;    // Next counter byte to read
		logic loaded;          // Counter loaded flag
		eng_t eng;             // Command engine state
		tap_state_t tap;       // Tracked target TAP state
		logic [PH_W-1:0] phase; // Position within one test clock period
		tap_pins_t pins;       // Pin outputs
		logic [7:0] out_sh;    // Outbound bits not yet sent
		logic [3:0] out_bits;  // Count of bits in out_sh
		logic [7:0] in_sh;     // Inbound bits being gathered
		logic [3:0] in_bits;   // Count of bits in in_sh
		logic in_push;         // Push gathered byte this cycle
		logic [7:0] in_byte;   // Byte being pushed
		logic tdi_s1;          // Synchroniser, first stage
		logic tdi_s2;          // Synchroniser, second stage
		logic prev_tdi;        // Last sampled scan bit
	} st_t;

	localparam st_t ST_RST = '{aw_free: 1'b1, w_free: 1'b1, ar_free: 1'b1,
		cmd: `RST_TEST_COMMAND, cfg: `RST_MODE_CONFIG, eng: ENG_IDLE, tap: TAP_RESET,
		pins: '{test_clk: 1'b0, mode_sel: 1'b1, scan_out: 1'b0, test_reset_n: 1'b1},
		default: '0};

	st_t s_q, s_d;
	op_use_t use_q;             // Decode of the current operation code
	tap_state_t fin;            // Finish state from the command
	logic wr_go, rd_go;         // Held bus request ready to act on
	logic start, flush;         // Command start and FIFO flush
	logic out_push, out_pop, in_pop;
	logic out_push_ready, out_pop_valid, in_push_ready, in_pop_valid;
	logic [7:0] out_pop_data, in_pop_data;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Next TAP state for one test clock with the given mode select
	function automatic tap_state_t tap_next(input tap_state_t c, input logic tms);
		logic [3:0] n;
		n = c;
		case (c[2:0])
			3'h0: n = (tms && !c[3]) ? TAP_RESET : (tms ? TAP_SEL_DR : TAP_IDLE);
			3'h1: n = c[3] ? (tms ? TAP_RESET : TAP_CAP_IR) : (tms ? TAP_SEL_IR : TAP_CAP_DR);
			3'h2, 3'h3: n = tms ? {c[3], 3'h4} : {c[3], 3'h3};
			3'h4: n = tms ? {c[3], 3'h7} : {c[3], 3'h5};
			3'h5: n = tms ? {c[3], 3'h6} : c;
			3'h6: n = tms ? {c[3], 3'h7} : {c[3], 3'h3};
			default: n = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return tap_state_t'(n);
	endfunction

	// Mode select bit that brings the target one step closer to the goal
	function automatic logic tms_toward(input tap_state_t c, input tap_state_t g);
		logic same_col;
		same_col = (g[3] == c[3]) && (g[2:1] != 2'b00);
		if (g == TAP_RESET) return 1'b1;
		if (c == TAP_RESET) return 1'b0;
		if (c[2:0] == 3'h1) return !same_col;
		return tap_next(c, 1'b0) != g;
	endfunction

	// What each operation code uses
	function automatic op_use_t op_use(input logic [3:0] op);
		op_use_t u;
		u = '0;
		u.valid = !(op inside {OP_NULL, OP_RESERVED});
		u.move_only = op == OP_MOVE;
		u.jump = op == OP_JUMP;
		u.cnt = u.valid && !u.move_only && !u.jump;
		u.addressable_port = op inside {OP_ASP_IN, OP_ASP_FULL, OP_ASP_OUT};
		u.inb = op inside {OP_ASP_IN, OP_ASP_FULL, OP_IR_FULL, OP_DR_FULL, OP_IR_IN,
			OP_DR_IN, OP_IR_RECIRC, OP_DR_RECIRC};
		u.outb = op inside {OP_ASP_FULL, OP_ASP_OUT, OP_IR_FULL, OP_DR_FULL, OP_IR_OUT,
			OP_DR_OUT};
		u.recirc = op inside {OP_IR_RECIRC, OP_DR_RECIRC};
		u.goal = op[3] ? (op[0] ? TAP_SHIFT_DR : TAP_SHIFT_IR) : TAP_IDLE;
		return u;
	endfunction

	// Finish state field to TAP state
	function automatic tap_state_t finish_of(input logic [1:0] f);
		case (f)
			2'b00: return TAP_RESET;
			2'b01: return TAP_IDLE;
			2'b10: return TAP_PAUSE_DR;
			default: return TAP_PAUSE_IR;
		endcase
	endfunction

	assign use_q = op_use(s_q.cmd[`CMD_OP_HI:`CMD_OP_LO]);
	assign fin = finish_of(s_q.cmd[`CMD_FINISH_HI:`CMD_FINISH_LO]);
	assign wr_go = !s_q.aw_free && !s_q.w_free && !s_q.bvalid;
	assign rd_go = !s_q.ar_free && !s_q.rvalid;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic done;
		logic [7:0] sh;
		logic [7:0] v;
		logic [3:0] nb;
		tap_state_t goal;
		st_t keep;
		op_use_t wu;
		done = 1'b0;
		sh = s_q.out_sh;
		v = s_q.in_sh;
		nb = s_q.in_bits;
		goal = (s_q.eng == ENG_ENTER) ? use_q.goal : fin;
		keep = s_q;
		// Decode of a command byte on offer, used by the start decision
		wu = op_use(s_q.w_data[`CMD_OP_HI:`CMD_OP_LO]);
		s_d = s_q;
		s_d.in_push = 1'b0;
		start = 1'b0;
		flush = 1'b0;
		out_push = 1'b0;
		out_pop = 1'b0;
		in_pop = 1'b0;
		// Scan input synchroniser
		s_d.tdi_s1 = scan_in;
		s_d.tdi_s2 = s_q.tdi_s1;
		// Bus channel capture and answer release
		if (s_q.aw_free && awvalid) begin
			s_d.aw_free = 1'b0;
			s_d.aw_addr = awaddr;
		end
		if (s_q.w_free && wvalid) begin
			s_d.w_free = 1'b0;
			s_d.w_data = wdata[7:0];
			s_d.w_lane0 = wstrb[0];
		end
		if (s_q.ar_free && arvalid) begin
			s_d.ar_free = 1'b0;
			s_d.ar_addr = araddr;
		end
		if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
		if (s_q.rvalid && rready) s_d.rvalid = 1'b0;

		// Command engine
		case (s_q.eng)
			ENG_IDLE: begin
				s_d.pins.test_clk = 1'b0;
			end
			ENG_WAIT: begin
				if (!use_q.cnt || s_q.loaded) begin
					if (use_q.jump) begin
						s_d.tap = fin;
						done = 1'b1;
					end else if (use_q.addressable_port) begin
						s_d.eng = ENG_WORK;
					end else if (use_q.move_only) begin
						s_d.eng = ENG_LEAVE;
					end else begin
						s_d.eng = ENG_ENTER;
					end
				end
			end
			default: begin
				if (s_q.phase == '0) begin
					// Decide the next test clock, or move on without one
					if (s_q.eng != ENG_WORK && s_q.tap == goal) begin
						if (s_q.eng == ENG_ENTER) s_d.eng = ENG_WORK;
						else done = 1'b1;
					end else if (s_q.eng != ENG_WORK) begin
						s_d.pins.mode_sel = tms_toward(s_q.tap, goal);
						s_d.phase = PH_W'(1);
					end else if (s_q.count == '0) begin
						if (use_q.addressable_port) done = 1'b1;
						else s_d.eng = ENG_LEAVE;
					end else if (!((use_q.outb && s_q.out_bits == '0 && !out_pop_valid) ||
						(use_q.inb && !in_push_ready))) begin
						// Bit cycle; starved buffers gate the test clock
						if (!use_q.addressable_port) s_d.pins.mode_sel = (use_q.goal != TAP_IDLE) &&
							(s_q.count == 32'h0000_0001);
						if (use_q.outb) begin
							if (s_q.out_bits == '0) begin
								out_pop = 1'b1;
								sh = out_pop_data;
								s_d.out_bits = 4'h7;
							end else begin
								s_d.out_bits = s_q.out_bits - 1'b1;
							end
							s_d.pins.scan_out = sh[0];
							s_d.out_sh = sh >> 1;
						end else begin
							s_d.pins.scan_out = use_q.recirc && s_q.prev_tdi;
						end
						s_d.phase = PH_W'(1);
					end
				end else begin
					s_d.phase = (s_q.phase == PH_W'(TCK_CYC - 1)) ? '0 : s_q.phase + 1'b1;
					s_d.pins.test_clk = s_q.phase >= PH_W'(HALF - 1) &&
						s_q.phase != PH_W'(TCK_CYC - 1);
					if (s_q.phase == PH_W'(TCK_CYC - 1)) begin
						// Late in the high half: sample and step the tracked state
						s_d.tap = tap_next(s_q.tap, s_q.pins.mode_sel);
						s_d.prev_tdi = s_q.tdi_s2;
						if (s_q.eng == ENG_WORK) begin
							s_d.count = s_q.count - 32'h0000_0001;
							if (use_q.addressable_port) s_d.tap = s_q.tap;
							if (use_q.inb) begin
								v = {s_q.tdi_s2, s_q.in_sh[7:1]};
								nb = s_q.in_bits + 1'b1;
								s_d.in_sh = v;
								s_d.in_bits = nb;
								if (nb == 4'h8 || s_q.count == 32'h0000_0001) begin
									s_d.in_push = 1'b1;
									s_d.in_byte = v >> (4'h8 - nb);
									s_d.in_bits = '0;
								end
							end
						end
					end
				end
			end
		endcase
		if (done) begin
			s_d.eng = ENG_IDLE;
			s_d.cmd[`CMD_OP_HI:`CMD_OP_LO] = OP_NULL;
		end

		// Bus write
		if (wr_go) begin
			s_d.aw_free = 1'b1;
			s_d.w_free = 1'b1;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RESP_OKAY;
			case (s_q.aw_addr)
				`OFF_TEST_COMMAND: begin
					if (s_q.w_lane0 && s_q.w_data[`CMD_SOFT_RESET_BIT]) begin
						// Keep this cycle's read channel, taken or answered, across the reset
						keep = s_d;
						s_d = ST_RST;
						s_d.bvalid = 1'b1;
						s_d.ar_free = keep.ar_free;
						s_d.ar_addr = keep.ar_addr;
						s_d.rvalid = keep.rvalid;
						s_d.rdata = keep.rdata;
						s_d.rresp = keep.rresp;
						flush = 1'b1;
					end else if (s_q.eng != ENG_IDLE) begin
						s_d.aw_free = 1'b0;
						s_d.w_free = 1'b0;
						s_d.bvalid = 1'b0;
					end else if (s_q.w_lane0) begin
						s_d.cmd = s_q.w_data;
						if (s_q.cfg[`CFG_DISCRETE_BIT] || !wu.valid) begin
							s_d.cmd[`CMD_OP_HI:`CMD_OP_LO] = OP_NULL;
						end else begin
							start = 1'b1;
							flush = 1'b1;
							s_d.eng = ENG_WAIT;
							s_d.phase = '0;
							s_d.out_bits = '0;
							s_d.in_bits = '0;
							s_d.in_push = 1'b0;
						end
					end
				end
				`OFF_CYCLE_COUNT_PORT: begin
					if (s_q.eng == ENG_IDLE && s_q.w_lane0) begin
						s_d.count[s_q.wr_idx*8 +: 8] = s_q.w_data;
						s_d.wr_idx = s_q.wr_idx + 1'b1;
						s_d.loaded = s_q.wr_idx == 2'h3;
					end
				end
				`OFF_OUTBOUND_SCAN_FIFO: begin
					if (!out_push_ready) begin
						s_d.aw_free = 1'b0;
						s_d.w_free = 1'b0;
						s_d.bvalid = 1'b0;
					end else begin
						out_push = s_q.w_lane0;
					end
				end
				`OFF_MODE_CONFIG: begin
					if (s_q.eng == ENG_IDLE && s_q.w_lane0) s_d.cfg = s_q.w_data;
				end
				`OFF_STATUS, `OFF_INBOUND_SCAN_FIFO: begin
				end
				default: s_d.bresp = `RESP_SLVERR;
			endcase
		end

		// Bus read
		if (rd_go) begin
			s_d.ar_free = 1'b1;
			s_d.rvalid = 1'b1;
			s_d.rresp = `RESP_OKAY;
			s_d.rdata = 8'h00;
			case (s_q.ar_addr)
				`OFF_TEST_COMMAND: s_d.rdata = s_q.cmd;
				`OFF_CYCLE_COUNT_PORT: begin
					s_d.rdata = s_q.count[s_q.rd_idx*8 +: 8];
					s_d.rd_idx = s_q.rd_idx + 1'b1;
				end
				`OFF_INBOUND_SCAN_FIFO: begin
					if (!in_pop_valid) begin
						s_d.ar_free = 1'b0;
						s_d.rvalid = 1'b0;
					end else begin
						s_d.rdata = in_pop_data;
						in_pop = 1'b1;
					end
				end
				`OFF_STATUS: s_d.rdata = {in_pop_valid, !out_push_ready, s_q.loaded, 1'b0, s_q.tap};
				`OFF_MODE_CONFIG: s_d.rdata = s_q.cfg;
				`OFF_OUTBOUND_SCAN_FIFO: begin
				end
				default: s_d.rresp = `RESP_SLVERR;
			endcase
		end
		// Test reset pin follows the command bit outside discrete mode
		s_d.pins.test_reset_n = s_d.cfg[`CFG_DISCRETE_BIT] | !s_d.cmd[`CMD_TRST_BIT];
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Scan buffers
	// ----------------------------------------------------------------
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_out_fifo (
		.clk(aclk), .rst_n(aresetn), .flush(flush),
		.push_valid(out_push), .push_ready(out_push_ready), .push_data(s_q.w_data),
		.pop_valid(out_pop_valid), .pop_ready(out_pop), .pop_data(out_pop_data)
	);
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_in_fifo (
		.clk(aclk), .rst_n(aresetn), .flush(flush),
		.push_valid(s_q.in_push && !flush), .push_ready(in_push_ready),
		.push_data(s_q.in_byte),
		.pop_valid(in_pop_valid), .pop_ready(in_pop), .pop_data(in_pop_data)
	);

	// Outputs, all from the state register
	assign awready = s_q.aw_free;
	assign wready = s_q.w_free;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.ar_free;
	assign rvalid = s_q.rvalid;
	assign rdata = {24'h00_0000, s_q.rdata};
	assign rresp = s_q.rresp;
	assign tap_out = s_q.pins;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic busy, cmd_wr, cnt_wr;
	assign busy = s_q.eng != ENG_IDLE;
	assign cmd_wr = wr_go && s_q.aw_addr == `OFF_TEST_COMMAND && s_q.w_lane0;
	assign cnt_wr = wr_go && s_q.aw_addr == `OFF_CYCLE_COUNT_PORT && s_q.w_lane0;

	cmd_hold_a: assert property (busy ##1 busy |-> $stable(s_q.cmd))
		else $error("command byte changed while busy");
	op_clear_a: assert property ($fell(busy) |-> s_q.cmd[3:0] == OP_NULL)
		else $error("operation code not null after completion");
	busy_stall_a: assert property (cmd_wr && !s_q.w_data[7] && busy |=> !s_q.bvalid)
		else $error("busy command write was answered");
	soft_reset_a: assert property (cmd_wr && s_q.w_data[7] |=> !busy && s_q.cmd == 8'h00 && s_q.bvalid)
		else $error("soft reset did not clear the block");
	trst_pin_a: assert property (!s_q.cfg[0] |-> s_q.pins.test_reset_n == !s_q.cmd[6])
		else $error("test reset pin disagrees with command bit");
	cnt_load_a: assert property (cnt_wr && !busy && s_q.wr_idx != 2'h3 |=> !s_q.loaded)
		else $error("counter flagged loaded too early");
	cnt_read_a: assert property (rd_go && s_q.ar_addr == `OFF_CYCLE_COUNT_PORT && !wr_go
		|=> $stable(s_q.loaded))
		else $error("counter read changed loaded flag");
	cnt_lsb_a: assert property (cnt_wr && !busy && s_q.wr_idx == 2'h0
		|=> s_q.count[7:0] == $past(s_q.w_data))
		else $error("first counter byte not the low byte");
	cnt_busy_a: assert property (cnt_wr && busy |=> $stable(s_q.wr_idx))
		else $error("counter write taken while busy");
	out_full_a: assert property (wr_go && s_q.aw_addr == `OFF_OUTBOUND_SCAN_FIFO && !out_push_ready
		|=> !s_q.bvalid)
		else $error("write to full outbound buffer answered");
	in_empty_a: assert property (rd_go && s_q.ar_addr == `OFF_INBOUND_SCAN_FIFO && !in_pop_valid
		|=> !s_q.rvalid)
		else $error("read of empty inbound buffer answered");
	start_flush_a: assert property (start |=> !out_pop_valid && !in_pop_valid)
		else $error("buffers not flushed at command start");
	discrete_skip_a: assert property (cmd_wr && !busy && s_q.cfg[0] |=> !busy)
		else $error("command started in discrete mode");
	wait_cnt_a: assert property (s_q.eng == ENG_WAIT && !s_q.loaded && use_q.cnt
		|=> s_q.eng inside {ENG_WAIT, ENG_IDLE})
		else $error("counting command ran before counter loaded");
	run_done_c: cover property (start ##[1:1000] $fell(busy));
	out_stall_c: cover property (wr_go && !out_push_ready ##[1:200] s_q.bvalid);
	in_stall_c: cover property (rd_go && !in_pop_valid ##[1:400] s_q.rvalid);
endmodule

// ---- tb/scan_target_model.sv ----
// Target chain model that echoes each shifted bit
`timescale 1ns/1ps
module scan_target_model
	import scan_pkg::*;
(
	input tap_pins_t tap_out,
	output logic scan_in
);
	// Capture on the rising test clock and hold until the next rise
	initial scan_in = 1'b0;
	always @(posedge tap_out.test_clk) begin
		scan_in <= tap_out.scan_out;
	end
endmodule

// ---- tb/scan_master_command_port_tb.sv ----
// Self-checking bench of the scan command port
`timescale 1ns/1ps
`include "scan_map.svh"
module scan_master_command_port_tb
	import scan_pkg::*;
;
	// ----------------
	// Signals
	// ----------------
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, scan_in;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, cnt;
	tap_pins_t tap_out;
	int failures = 0, check_count = 0, cyc = 0;
	logic [17:0] rq[$]; // Read notes: answer code, expected and mask
	logic [1:0] bq[$]; // Write response notes
	logic [7:0] d;
	logic [7:0] bs[5]; // Scan bytes sent and expected back
	logic [7:0] cmds[4] = '{8'h16, 8'h26, 8'h37, 8'h06};
	logic [3:0] taps[4] = '{4'h8, 4'h5, 4'hd, 4'h0};
	always #50 aclk = ~aclk;
	scan_master_command_port uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp, .scan_in, .tap_out);
	scan_target_model target (.tap_out, .scan_in);
	// ----------------
	// Tasks
	// ----------------
	task chk(input logic ok);
		check_count++;
		if (!ok) begin
			failures++;
			$display("Error %0t: mismatch", $time);
		end
	endtask
	task stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Write: both channels offered together, held until taken
	task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
		@(posedge aclk);
		bq.push_back(er);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= a;
		wdata <= {24'h0, v};
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	// Read: note expectation, hold request until taken, then wait for the answer
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge aclk);
		rq.push_back({(a <= `OFF_MODE_CONFIG && a[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR,
			e & m, m});
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= a;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata[7:0];
		rready <= 1'b0;
	endtask
	// Poll the command until its code returns to null
	task poll;
		do rd(`OFF_TEST_COMMAND, 8'h00, 8'h00); while (d[3:0] !== 4'h0);
	endtask
	task cntw(input logic [31:0] v);
		for (int i = 0; i < 4; i++) wr(`OFF_CYCLE_COUNT_PORT, v[8*i+:8], `RESP_OKAY);
	endtask
	// ----------------
	// Monitor and watchdog
	// ----------------
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			chk((rdata[7:0] & rq[0][7:0]) === rq[0][15:8]);
			chk(rresp === rq[0][17:16] && rdata[31:8] === 24'h00_0000);
			void'(rq.pop_front());
		end
		if (bvalid && bready) chk(bresp === bq.pop_front());
		cyc++;
		if (cyc == 50000) begin
			failures++;
			stop_test;
		end
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		void'($urandom(41106));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OFF_TEST_COMMAND, `RST_TEST_COMMAND, 8'hff);
		wr(`OFF_TEST_COMMAND, 8'h40, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(tap_out.test_reset_n === 1'b0);
		wr(`OFF_TEST_COMMAND, 8'h00, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(tap_out.test_reset_n === 1'b1);
		wr(8'h20, 8'h00, `RESP_SLVERR);
		rd(8'h20, 8'h00, 8'hff);
		// Counter bytes low first, flag only after the fourth
		cnt = $urandom;
		for (int i = 0; i < 3; i++) wr(`OFF_CYCLE_COUNT_PORT, cnt[8*i+:8], `RESP_OKAY);
		rd(`OFF_STATUS, 8'h00, 8'h20);
		wr(`OFF_CYCLE_COUNT_PORT, cnt[31:24], `RESP_OKAY);
		rd(`OFF_STATUS, 8'h20, 8'h20);
		for (int i = 0; i < 4; i++) rd(`OFF_CYCLE_COUNT_PORT, cnt[8*i+:8], 8'hff);
		rd(`OFF_STATUS, 8'h20, 8'h20);
		// Every finish state through move and jump
		foreach (cmds[i]) begin
			wr(`OFF_TEST_COMMAND, cmds[i], `RESP_OKAY);
			poll;
			rd(`OFF_STATUS, {4'h0, taps[i]}, 8'h0f);
		end
		// Forty-bit data scan echoed by the target; the fifth byte meets a full buffer
		cntw(32'h28);
		wr(`OFF_TEST_COMMAND, 8'h19, `RESP_OKAY);
		rd(`OFF_TEST_COMMAND, 8'h19, 8'hff);
		foreach (bs[i]) begin
			bs[i] = 8'($urandom);
			wr(`OFF_OUTBOUND_SCAN_FIFO, bs[i], `RESP_OKAY);
		end
		foreach (bs[i]) rd(`OFF_INBOUND_SCAN_FIFO, bs[i], 8'hff);
		poll;
		rd(`OFF_STATUS, 8'h08, 8'h0f);
		// Command written during a run test waits for its end
		cntw(32'h4);
		wr(`OFF_TEST_COMMAND, 8'h12, `RESP_OKAY);
		wr(`OFF_TEST_COMMAND, 8'h16, `RESP_OKAY);
		poll;
		rd(`OFF_CYCLE_COUNT_PORT, 8'h00, 8'hff);
		rd(`OFF_STATUS, 8'h08, 8'h0f);
		// Discrete mode stores the command with a null code
		wr(`OFF_MODE_CONFIG, 8'h01, `RESP_OKAY);
		wr(`OFF_TEST_COMMAND, 8'h16, `RESP_OKAY);
		rd(`OFF_TEST_COMMAND, 8'h10, 8'hff);
		wr(`OFF_MODE_CONFIG, 8'h00, `RESP_OKAY);
		// Soft reset while a scan with no outbound data is still entering its shift state
		cntw(32'h8);
		wr(`OFF_TEST_COMMAND, 8'h19, `RESP_OKAY);
		wr(`OFF_TEST_COMMAND, 8'h80, `RESP_OKAY);
		rd(`OFF_TEST_COMMAND, 8'h00, 8'hff);
		rd(`OFF_STATUS, 8'h00, 8'h20);
		// A counting command waits on an unloaded counter, which it cannot load
		wr(`OFF_TEST_COMMAND, 8'h12, `RESP_OKAY);
		cntw(32'h4);
		rd(`OFF_TEST_COMMAND, 8'h12, 8'hff);
		rd(`OFF_STATUS, 8'h00, 8'h2f);
		wr(`OFF_TEST_COMMAND, 8'h80, `RESP_OKAY);
		rd(`OFF_TEST_COMMAND, 8'h00, 8'hff);
		stop_test;
	end
endmodule
